/* File: src/aslu_pkg.sv */
// Purpose: shared constants and types of the serial transceiver core
// Assumes: 8-bit cpu data, 16-bit cpu addresses
// Notes: one base clock tick per falling edge of the internal base clock
package aslu_pkg;
  // ***************************************************
  // register map
  // ***************************************************
  localparam logic [15:0] ADR_MODE = 16'hff50;
  localparam logic [15:0] ADR_TXB = 16'hff51;
  localparam logic [15:0] ADR_RXB = 16'hff52;
  localparam logic [15:0] ADR_ERR = 16'hff53;
  localparam logic [15:0] ADR_TXST = 16'hff55;
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] BUF_RST = 8'hff;
  localparam logic [7:0] STAT_RST = 8'h00;
  // ***************************************************
  // field positions
  // ***************************************************
  localparam int B_POWER = 7;
  localparam int B_TXE = 6;
  localparam int B_RXE = 5;
  localparam int B_PSH = 4;
  localparam int B_PSL = 3;
  localparam int B_LEN = 2;
  localparam int B_STOP = 1;
  localparam int B_ROUTE = 0;
  localparam int B_PE = 2;
  localparam int B_FE = 1;
  localparam int B_OVE = 0;
  localparam int B_TXBF = 1;
  localparam int B_TXSF = 0;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  // ***************************************************
  // timing counts
  // ***************************************************
  localparam int BASE_HALF_CLKS = 1;
  localparam int BIT_BASE_CLKS = 16;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_START = 5'h02, ST_DATA = 5'h04, ST_PAR = 5'h08, ST_STOP = 5'h10
  } aslu_st_e;
endpackage

/* File: src/aslu_tick_if.sv */
// Purpose: base clock tick carrier between divider and core
// Assumes: one system clock
// Notes: base_fall is a one-cycle pulse
`timescale 1ns/1ps
interface aslu_tick_if;
  logic base_clk;
  logic base_fall;
  modport src (output base_clk, output base_fall);
  modport snk (input base_clk, input base_fall);
endinterface

/* File: src/aslu_base_clk.sv */
// Purpose: internal base clock divider, held low while gated
// Assumes: i_rst_b low stops the clock at low level
// Notes: base_fall marks each falling edge
`timescale 1ns/1ps
module aslu_base_clk #(
  parameter int HALF_CLKS = aslu_pkg::BASE_HALF_CLKS
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  aslu_tick_if.src t
);
  import aslu_pkg::*;
  logic [7:0] cnt_r, cnt_nxt;
  logic clk_r, clk_nxt;
  logic fall_r, fall_nxt;
  always_comb begin
    cnt_nxt = cnt_r + 8'h01;
    clk_nxt = clk_r;
    fall_nxt = 1'b0;
    if (cnt_r == 8'(HALF_CLKS - 1)) begin
      cnt_nxt = 8'h00;
      clk_nxt = ~clk_r;
      fall_nxt = clk_r;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= 8'h00;
      clk_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      clk_r <= clk_nxt;
      fall_r <= fall_nxt;
    end
  end
  assign t.base_clk = clk_r;
  assign t.base_fall = fall_r;
endmodule

/* File: src/aslu_core.sv */
// Purpose: asynchronous serial transceiver core with mode, buffers and shifters
// Assumes: base clock derived internally; bit time is a fixed count of base clocks
// Notes: power gate low holds the whole serial circuit in reset
// Notes on behaviour
// RULE1 - 7-bit lsb-first: bits 0..6, top zero
// RULE2 - 7-bit msb-first: bits 1..7, bit 0 zero
// RULE3 - overrun keeps old receive buffer contents
// RULE4 - receive buffer read-only, resets ff, loads per character
// RULE5 - transmit buffer write starts sending, resets ff
// RULE6 - shifter loads after first write or frame end
// RULE7 - load and shift on base clock falling edge
// RULE8 - no write while buffer full flag set
// RULE9 - no same-value rewrite while communicating
// RULE10 - wait one base clock after transmit enable
// RULE11 - mode register resets 01, fixed field layout
// RULE12 - power gate low resets circuit, pin high
// RULE13 - enable low synchronously resets its half
// RULE14 - parity field: none, zero, odd, even
// RULE15 - zero parity never flags parity error
// RULE16 - length bit selects 7 or 8 bits
// RULE17 - stop bits set transmit only; receive checks one
// RULE18 - routing bit picks error or complete interrupt
// RULE19 - power gate on first, off last
// RULE20 - receiver enabled on low line starts receiving
// RULE21 - enables synced to base clock, two-clock gap
// RULE22 - change mode fields only while disabled
`timescale 1ns/1ps
module aslu_core #(
  parameter int BIT_CLKS = aslu_pkg::BIT_BASE_CLKS,
  parameter int HALF_CLKS = aslu_pkg::BASE_HALF_CLKS
) (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic [15:0] I_ADDR,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] I_WDATA,
  output logic [7:0] O_RDATA,
  input wire logic I_MSB_FIRST,
  input wire logic I_SERIAL_IN_PIN,
  output logic O_SERIAL_OUT_PIN,
  output logic O_RECEIVE_COMPLETE_IRQ,
  output logic O_RECEIVE_ERROR_IRQ,
  output logic O_TRANSMIT_COMPLETE_IRQ
);
  import aslu_pkg::*;
  localparam int LOAD_WAIT = 2 * HALF_CLKS + 2;
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction
  function automatic logic [7:0] rev8(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = d[7 - i];
    end
  endfunction
  // ***************************************************
  // cpu registers
  // ***************************************************
  logic [7:0] mode_r, mode_nxt, txb_r, txb_nxt, rdata_r, rdata_nxt;
  logic core_rst_b, base_fall, txb_wr, rd_rxb, rd_err;
  logic [7:0] rxb_r, err_r, txst;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!core_rst_b);
  assign core_rst_b = I_RST_B & mode_r[B_POWER];
  assign txb_wr = I_WR & hit(I_ADDR, ADR_TXB);
  assign rd_rxb = I_RD & hit(I_ADDR, ADR_RXB);
  assign rd_err = I_RD & hit(I_ADDR, ADR_ERR);
  always_comb begin
    mode_nxt = mode_r;
    txb_nxt = txb_r;
    rdata_nxt = rdata_r;
    if (I_WR && hit(I_ADDR, ADR_MODE)) begin
      mode_nxt = I_WDATA;
    end
    if (txb_wr) begin
      txb_nxt = I_WDATA;
    end
    if (I_RD) begin
      rdata_nxt = 8'h00;
      if (hit(I_ADDR, ADR_MODE)) rdata_nxt = mode_r;
      if (hit(I_ADDR, ADR_TXB)) rdata_nxt = txb_r;
      if (hit(I_ADDR, ADR_RXB)) rdata_nxt = rxb_r;
      if (hit(I_ADDR, ADR_ERR)) rdata_nxt = err_r;
      if (hit(I_ADDR, ADR_TXST)) rdata_nxt = txst;
    end
  end
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mode_r <= MODE_RST; // [RULE11]
      txb_r <= BUF_RST; // [RULE5]
      rdata_r <= 8'h00;
    end else begin
      mode_r <= mode_nxt;
      txb_r <= txb_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign O_RDATA = rdata_r;
  // ***************************************************
  // base clock and enable sync
  // ***************************************************
  aslu_tick_if tick ();
  aslu_base_clk #(.HALF_CLKS(HALF_CLKS)) u_base (.i_clk(I_CLK), .i_rst_b(core_rst_b), .t(tick));
  assign base_fall = tick.base_fall;
  logic tx_en_r, tx_en_nxt, rx_en_r, rx_en_nxt;
  logic [2:0] sync_r, sync_nxt;
  logic rx_in_r, rx_in_nxt;
  always_comb begin
    tx_en_nxt = base_fall ? mode_r[B_TXE] : tx_en_r; // [RULE21]
    rx_en_nxt = base_fall ? mode_r[B_RXE] : rx_en_r; // [RULE21]
    sync_nxt = {sync_r[1:0], I_SERIAL_IN_PIN};
    rx_in_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : rx_in_r;
  end
  always_ff @(posedge I_CLK or negedge core_rst_b) begin
    if (!core_rst_b) begin
      tx_en_r <= 1'b0;
      rx_en_r <= 1'b0;
      sync_r <= 3'h7;
      rx_in_r <= 1'b1; // [RULE12]
    end else begin
      tx_en_r <= tx_en_nxt;
      rx_en_r <= rx_en_nxt;
      sync_r <= sync_nxt;
      rx_in_r <= rx_in_nxt;
    end
  end
  // ***************************************************
  // transmitter
  // ***************************************************
  aslu_st_e tx_st_r, tx_st_nxt;
  logic [7:0] txs_r, txs_nxt, tx_cnt_r, tx_cnt_nxt;
  logic [2:0] tx_idx_r, tx_idx_nxt;
  logic txbf_r, txbf_nxt, txsf_r, txsf_nxt, tx_out_r, tx_out_nxt;
  logic tx_par_r, tx_par_nxt, tx_stp_r, tx_stp_nxt, tx_irq_r, tx_irq_nxt;
  logic [7:0] tx_load;
  logic [2:0] last_idx;
  assign last_idx = mode_r[B_LEN] ? 3'h7 : 3'h6; // [RULE16]
  assign tx_load = I_MSB_FIRST ? rev8(txb_r) : txb_r;
  assign txst = {6'h00, txbf_r, txsf_r};
  always_comb begin
    logic [7:0] dm;
    dm = mode_r[B_LEN] ? tx_load : {1'b0, tx_load[6:0]};
    tx_st_nxt = tx_st_r;
    txs_nxt = txs_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_idx_nxt = tx_idx_r;
    txbf_nxt = txbf_r;
    txsf_nxt = txsf_r;
    tx_out_nxt = tx_out_r;
    tx_par_nxt = tx_par_r;
    tx_stp_nxt = tx_stp_r;
    tx_irq_nxt = 1'b0;
    if (!tx_en_r) begin
      tx_st_nxt = ST_IDLE; // [RULE13]
      txbf_nxt = 1'b0;
      txsf_nxt = 1'b0;
      tx_out_nxt = 1'b1;
      tx_cnt_nxt = 8'h00;
    end else begin
      if (txb_wr) txbf_nxt = 1'b1; // [RULE5]
      if (base_fall) begin // [RULE7]
        tx_cnt_nxt = tx_cnt_r + 8'h01;
        if (tx_cnt_r == 8'(BIT_CLKS - 1)) tx_cnt_nxt = 8'h00;
        unique case (tx_st_r)
          ST_IDLE: begin
            tx_cnt_nxt = 8'h00;
          end
          ST_START: begin
            if (tx_cnt_r == 8'(BIT_CLKS - 1)) begin
              tx_st_nxt = ST_DATA;
              tx_out_nxt = txs_r[0];
              tx_idx_nxt = 3'h0;
            end
          end
          ST_DATA: begin
            if (tx_cnt_r == 8'(BIT_CLKS - 1)) begin
              txs_nxt = {1'b1, txs_r[7:1]};
              tx_out_nxt = txs_r[1];
              tx_idx_nxt = tx_idx_r + 3'h1;
              if (tx_idx_r == last_idx) begin
                tx_st_nxt = (mode_r[B_PSH:B_PSL] == PAR_NONE) ? ST_STOP : ST_PAR; // [RULE14]
                tx_out_nxt = (mode_r[B_PSH:B_PSL] == PAR_NONE) ? 1'b1 : tx_par_r;
                tx_stp_nxt = 1'b0;
              end
            end
          end
          ST_PAR: begin
            if (tx_cnt_r == 8'(BIT_CLKS - 1)) begin
              tx_st_nxt = ST_STOP;
              tx_out_nxt = 1'b1;
            end
          end
          ST_STOP: begin
            if (tx_cnt_r == 8'(BIT_CLKS - 1)) begin
              if (mode_r[B_STOP] && !tx_stp_r) begin
                tx_stp_nxt = 1'b1; // [RULE17]
              end else begin
                tx_irq_nxt = 1'b1;
                tx_st_nxt = ST_IDLE;
                txsf_nxt = 1'b0;
              end
            end
          end
        endcase
        if (txbf_r && (tx_st_r == ST_IDLE || tx_irq_nxt)) begin // [RULE6]
          txs_nxt = tx_load;
          txbf_nxt = 1'b0;
          txsf_nxt = 1'b1;
          tx_st_nxt = ST_START;
          tx_out_nxt = 1'b0;
          tx_cnt_nxt = 8'h00;
          unique case (mode_r[B_PSH:B_PSL]) // [RULE14]
            PAR_ODD: tx_par_nxt = ~(^dm);
            PAR_EVEN: tx_par_nxt = ^dm;
            default: tx_par_nxt = 1'b0;
          endcase
        end
      end
    end
  end
  always_ff @(posedge I_CLK or negedge core_rst_b) begin
    if (!core_rst_b) begin
      tx_st_r <= ST_IDLE;
      txs_r <= BUF_RST;
      tx_cnt_r <= 8'h00;
      tx_idx_r <= 3'h0;
      txbf_r <= 1'b0;
      txsf_r <= 1'b0;
      tx_out_r <= 1'b1; // [RULE12]
      tx_par_r <= 1'b0;
      tx_stp_r <= 1'b0;
      tx_irq_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      txs_r <= txs_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_idx_r <= tx_idx_nxt;
      txbf_r <= txbf_nxt;
      txsf_r <= txsf_nxt;
      tx_out_r <= tx_out_nxt;
      tx_par_r <= tx_par_nxt;
      tx_stp_r <= tx_stp_nxt;
      tx_irq_r <= tx_irq_nxt;
    end
  end
  assign O_SERIAL_OUT_PIN = tx_out_r;
  assign O_TRANSMIT_COMPLETE_IRQ = tx_irq_r;
  // ***************************************************
  // receiver
  // ***************************************************
  aslu_st_e rx_st_r, rx_st_nxt;
  logic [7:0] rxs_r, rxs_nxt, rx_cnt_r, rx_cnt_nxt, rxb_nxt, err_nxt, rx_data;
  logic [2:0] rx_idx_r, rx_idx_nxt;
  logic rx_pb_r, rx_pb_nxt, full_r, full_nxt, rx_mid, rx_finish, rx_pe, rx_bad;
  logic ok_irq_r, ok_irq_nxt, err_irq_r, err_irq_nxt, rxb_load_r, rxb_load_nxt;
  assign rx_mid = base_fall && (rx_cnt_r == 8'(BIT_CLKS - 1));
  assign rx_finish = rx_en_r && rx_mid && (rx_st_r == ST_STOP);
  always_comb begin
    logic [7:0] d;
    d = mode_r[B_LEN] ? rxs_r : {1'b0, rxs_r[7:1]};
    rx_data = I_MSB_FIRST ? rev8(d) : d; // [RULE1] [RULE2]
    unique case (mode_r[B_PSH:B_PSL]) // [RULE15]
      PAR_ODD: rx_pe = ~(^d ^ rx_pb_r);
      PAR_EVEN: rx_pe = ^d ^ rx_pb_r;
      default: rx_pe = 1'b0;
    endcase
    rx_bad = rx_pe | ~rx_in_r | full_r;
  end
  always_comb begin
    rx_st_nxt = rx_st_r;
    rxs_nxt = rxs_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_idx_nxt = rx_idx_r;
    rx_pb_nxt = rx_pb_r;
    rxb_nxt = rxb_r;
    err_nxt = rd_err ? STAT_RST : err_r;
    full_nxt = rd_rxb ? 1'b0 : full_r;
    ok_irq_nxt = 1'b0;
    err_irq_nxt = 1'b0;
    rxb_load_nxt = 1'b0;
    if (!rx_en_r) begin
      rx_st_nxt = ST_IDLE; // [RULE13]
      rx_cnt_nxt = 8'h00;
      err_nxt = STAT_RST;
    end else if (base_fall) begin
      rx_cnt_nxt = rx_mid ? 8'h00 : rx_cnt_r + 8'h01;
      unique case (rx_st_r)
        ST_IDLE: begin
          rx_cnt_nxt = 8'(BIT_CLKS / 2);
          if (!rx_in_r) rx_st_nxt = ST_START; // [RULE20]
        end
        ST_START: begin
          if (rx_mid) begin
            rx_st_nxt = rx_in_r ? ST_IDLE : ST_DATA;
            rx_idx_nxt = 3'h0;
          end
        end
        ST_DATA: begin
          if (rx_mid) begin
            rxs_nxt = {rx_in_r, rxs_r[7:1]};
            rx_idx_nxt = rx_idx_r + 3'h1;
            if (rx_idx_r == last_idx) begin // [RULE16]
              rx_st_nxt = (mode_r[B_PSH:B_PSL] == PAR_NONE) ? ST_STOP : ST_PAR;
            end
          end
        end
        ST_PAR: begin
          if (rx_mid) begin
            rx_pb_nxt = rx_in_r;
            rx_st_nxt = ST_STOP;
          end
        end
        ST_STOP: begin
          if (rx_mid) begin // [RULE17]
            rx_st_nxt = ST_IDLE;
            err_nxt[B_PE] = err_nxt[B_PE] | rx_pe;
            err_nxt[B_FE] = err_nxt[B_FE] | ~rx_in_r;
            err_nxt[B_OVE] = err_nxt[B_OVE] | full_r;
            if (!full_r) begin // [RULE3]
              rxb_nxt = rx_data; // [RULE4]
              full_nxt = 1'b1;
              rxb_load_nxt = 1'b1;
            end
            err_irq_nxt = rx_bad & ~mode_r[B_ROUTE]; // [RULE18]
            ok_irq_nxt = ~rx_bad | mode_r[B_ROUTE];
          end
        end
      endcase
    end
  end
  always_ff @(posedge I_CLK or negedge core_rst_b) begin
    if (!core_rst_b) begin
      rx_st_r <= ST_IDLE;
      rxs_r <= BUF_RST;
      rx_cnt_r <= 8'h00;
      rx_idx_r <= 3'h0;
      rx_pb_r <= 1'b0;
      rxb_r <= BUF_RST; // [RULE4] [RULE12]
      err_r <= STAT_RST;
      full_r <= 1'b0;
      ok_irq_r <= 1'b0;
      err_irq_r <= 1'b0;
      rxb_load_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rxs_r <= rxs_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_idx_r <= rx_idx_nxt;
      rx_pb_r <= rx_pb_nxt;
      rxb_r <= rxb_nxt;
      err_r <= err_nxt;
      full_r <= full_nxt;
      ok_irq_r <= ok_irq_nxt;
      err_irq_r <= err_irq_nxt;
      rxb_load_r <= rxb_load_nxt;
    end
  end
  assign O_RECEIVE_COMPLETE_IRQ = ok_irq_r;
  assign O_RECEIVE_ERROR_IRQ = err_irq_r;
  // ***************************************************
  // checks
  // ***************************************************
  property p_rx_lsb7; rxb_load_r && !mode_r[B_LEN] && !I_MSB_FIRST |-> !rxb_r[7]; endproperty
  a_rx_lsb7: assert property (p_rx_lsb7) else $error("lsb 7-bit top bit set"); // [RULE1]
  property p_rx_msb7; rxb_load_r && !mode_r[B_LEN] && I_MSB_FIRST |-> !rxb_r[0]; endproperty
  a_rx_msb7: assert property (p_rx_msb7) else $error("msb 7-bit low bit set"); // [RULE2]
  property p_overrun; rx_finish && full_r && !rd_rxb |=> $stable(rxb_r) && err_r[B_OVE]; endproperty
  a_overrun: assert property (p_overrun) else $error("overrun overwrote buffer"); // [RULE3]
  property p_rxb_ro; I_WR && hit(I_ADDR, ADR_RXB) && !rx_finish |=> $stable(rxb_r); endproperty
  a_rxb_ro: assert property (p_rxb_ro) else $error("receive buffer took a write"); // [RULE4]
  property p_tx_start;
    txb_wr && tx_en_r && mode_r[B_TXE] && tx_st_r == ST_IDLE && !txbf_r |=> ##[0:LOAD_WAIT] (txsf_r && !O_SERIAL_OUT_PIN);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("write did not start frame"); // [RULE5]
  property p_tx_edge; $changed(O_SERIAL_OUT_PIN) && $past(tx_en_r) |-> $past(base_fall); endproperty
  a_tx_edge: assert property (p_tx_edge) else $error("pin moved off base clock fall"); // [RULE7]
  property p_power_off; @(posedge I_CLK) disable iff (!I_RST_B)
    !mode_r[B_POWER] |-> O_SERIAL_OUT_PIN && !tick.base_clk && rxb_r == BUF_RST && (err_r | txst) == STAT_RST;
  endproperty
  a_power_off: assert property (p_power_off) else $error("power gate off not in reset"); // [RULE12]
  property p_tx_srst; !tx_en_r |=> !txbf_r && !txsf_r && O_SERIAL_OUT_PIN; endproperty
  a_tx_srst: assert property (p_tx_srst) else $error("transmit not reset while disabled"); // [RULE13]
  property p_zero_par; rx_finish && mode_r[B_PSH:B_PSL] == PAR_ZERO && !err_r[B_PE] |=> !err_r[B_PE]; endproperty
  a_zero_par: assert property (p_zero_par) else $error("zero parity flagged"); // [RULE15]
  property p_route;
    rx_finish && rx_bad |=> (mode_r[B_ROUTE] ? (ok_irq_r && !err_irq_r) : (err_irq_r && !ok_irq_r));
  endproperty
  a_route: assert property (p_route) else $error("error interrupt misrouted"); // [RULE18]
  c_tx_done: cover property (tx_irq_r);
  c_rx_done: cover property (ok_irq_r && !rx_bad);
  c_rx_err: cover property (err_irq_r);
  c_back2back: cover property (tx_irq_r && txsf_r);
endmodule

/* File: testbench/aslu_remote_node.sv */
// Purpose: remote serial node model facing the transceiver core
// Assumes: bit time of BT system clocks, line idle high
// Notes: frames seen on the core's output are queued, lsb first
`timescale 1ns/1ps
module aslu_remote_node #(
  parameter int BT = 8
) (
  input wire logic i_clk,
  input wire logic i_line,
  input wire logic [3:0] i_nbits,
  output logic o_line
);
  // ****
  // sender
  // ****
  logic [11:0] rx_q[$];
  logic [11:0] w;
  initial o_line = 1'b1;
  task automatic send(input logic [11:0] b, input int n);
    @(negedge i_clk);
    o_line = 1'b0;
    repeat (BT) @(negedge i_clk);
    for (int k = 0; k < n; k++) begin
      o_line = b[k];
      repeat (BT) @(negedge i_clk);
    end
    o_line = 1'b1;
    repeat (2 * BT) @(negedge i_clk);
  endtask
  // ****
  // receiver, samples at mid bit
  // ****
  always begin
    @(negedge i_line);
    repeat (BT / 2) @(negedge i_clk);
    if (i_line === 1'b0) begin
      w = '0;
      for (int k = 0; k < int'(i_nbits); k++) begin
        repeat (BT) @(negedge i_clk);
        w[k] = i_line;
      end
      rx_q.push_back(w);
    end
  end
endmodule

/* File: testbench/aslu_core_tb.sv */
// Purpose: self-checking bench of the serial transceiver core
// Assumes: BIT_CLKS 4, HALF_CLKS 1, so one bit is 8 clocks
// Notes: inputs change on falling clock edges
`timescale 1ns/1ps
module aslu_core_tb;
  import aslu_pkg::*;
  localparam int BT = 8;
  logic I_CLK = 1'b0;
  logic I_RST_B = 1'b0;
  logic [15:0] I_ADDR = '0;
  logic I_WR = 1'b0;
  logic I_RD = 1'b0;
  logic [7:0] I_WDATA = '0;
  logic I_MSB_FIRST = 1'b0;
  logic [7:0] O_RDATA;
  logic ser_in;
  logic O_SERIAL_OUT_PIN;
  logic O_RECEIVE_COMPLETE_IRQ;
  logic O_RECEIVE_ERROR_IRQ;
  logic O_TRANSMIT_COMPLETE_IRQ;
  logic [3:0] nb = 4'h9;
  int n_errors = 0;
  int checked = 0;
  int n_rc = 0;
  int n_re = 0;
  int n_tc = 0;
  int cyc = 0;
  aslu_core #(.BIT_CLKS(4), .HALF_CLKS(1)) u_aslu_core (
    .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD),
    .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .I_MSB_FIRST(I_MSB_FIRST),
    .I_SERIAL_IN_PIN(ser_in), .O_SERIAL_OUT_PIN(O_SERIAL_OUT_PIN),
    .O_RECEIVE_COMPLETE_IRQ(O_RECEIVE_COMPLETE_IRQ), .O_RECEIVE_ERROR_IRQ(O_RECEIVE_ERROR_IRQ),
    .O_TRANSMIT_COMPLETE_IRQ(O_TRANSMIT_COMPLETE_IRQ)
  );
  aslu_remote_node #(.BT(BT)) u_aslu_remote_node (
    .i_clk(I_CLK), .i_line(O_SERIAL_OUT_PIN), .i_nbits(nb), .o_line(ser_in)
  );
  always #20 I_CLK = ~I_CLK;
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    n_rc <= n_rc + int'(O_RECEIVE_COMPLETE_IRQ === 1'b1);
    n_re <= n_re + int'(O_RECEIVE_ERROR_IRQ === 1'b1);
    n_tc <= n_tc + int'(O_TRANSMIT_COMPLETE_IRQ === 1'b1);
  end
  // ****
  // shared tasks
  // ****
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkn(input int g, input int e);
    checked++;
    if (g != e) begin
      n_errors++;
      $display("mismatch at %0t: count %0d exp %0d", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge I_CLK);
    I_ADDR = a;
    I_WDATA = d;
    I_WR = 1'b1;
    @(negedge I_CLK);
    I_WR = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge I_CLK);
    I_ADDR = a;
    I_RD = 1'b1;
    @(negedge I_CLK);
    I_RD = 1'b0;
    d = O_RDATA;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(12'(v), 12'(e));
  endtask
  task automatic wait_tc(input int target);
    for (int k = 0; k < 600 && n_tc < target; k++) @(negedge I_CLK);
    if (n_tc < target) begin
      n_errors++;
      $display("mismatch at %0t: transmit wait timeout", $time);
      end_sim();
    end
  endtask
  task automatic cfg(input logic [7:0] m, input logic msb);
    wr(ADR_MODE, 8'h80 | (m & 8'h1f));
    repeat (6) @(negedge I_CLK);
    I_MSB_FIRST = msb;
    wr(ADR_MODE, m);
    repeat (4) @(negedge I_CLK);
  endtask
  function automatic logic [11:0] tx_bits(input logic [7:0] m, input logic [7:0] d);
    logic [11:0] r;
    int nd;
    nd = m[2] ? 8 : 7;
    r = m[2] ? {4'h0, d} : {5'h00, d[6:0]};
    if (m[4:3] == 2'b10)
      r[nd] = ~^r[7:0];
    if (m[4:3] == 2'b11)
      r[nd] = ^r[7:0];
    r[nd + int'(m[4:3] != 2'b00)] = 1'b1;
    return r;
  endfunction
  task automatic tx_one(input logic [7:0] m, input logic [7:0] d, input logic msb);
    int nd;
    int pp;
    int ts;
    logic [7:0] e;
    nd = m[2] ? 8 : 7;
    pp = int'(m[4:3] != 2'b00);
    ts = -1;
    e = d;
    if (msb)
      e = {<<{d}};
    cfg(m, msb);
    nb = 4'(nd + pp + 1);
    wr(ADR_TXB, d);
    for (int k = 0; k < 40 && ts < 0; k++) begin
      @(negedge I_CLK);
      if (O_SERIAL_OUT_PIN === 1'b0)
        ts = cyc;
    end
    if (ts < 0) begin
      n_errors++;
      $display("mismatch at %0t: start bit wait timeout", $time);
      end_sim();
    end
    wait_tc(n_tc + 1);
    ts = cyc - ts - (1 + nd + pp + (m[1] ? 2 : 1)) * BT;
    chkn(int'(ts >= -2 && ts <= 3), 1);
    repeat (BT) @(negedge I_CLK);
    chkn(u_aslu_remote_node.rx_q.size(), 1);
    chk(u_aslu_remote_node.rx_q.pop_front(), tx_bits(m, e));
  endtask
  task automatic rx_chk(input logic [11:0] raw, input int n, input bit rb, input logic [7:0] eb,
                        input logic [7:0] ee, input int drc, input int dre);
    int rc0;
    int re0;
    rc0 = n_rc;
    re0 = n_re;
    u_aslu_remote_node.send(raw, n);
    rdc(ADR_ERR, ee);
    if (rb)
      rdc(ADR_RXB, eb);
    chkn(n_rc - rc0, drc);
    chkn(n_re - re0, dre);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    rdc(ADR_MODE, 8'h01);
    rdc(ADR_TXB, 8'hff);
    rdc(ADR_RXB, 8'hff);
    wr(ADR_MODE, 8'h80);
    wr(ADR_RXB, 8'h12);
    rdc(ADR_RXB, 8'hff);
    wr(ADR_TXB, 8'h3c);
    rdc(ADR_TXB, 8'h3c);
    rdc(16'hff5f, 8'h00);
  endtask
  task automatic t_tx;
    logic [7:0] modes [6];
    modes = '{8'hc4, 8'hc0, 8'hc8, 8'hd4, 8'hdc, 8'hc6};
    for (int i = 0; i < 6; i++)
      tx_one(modes[i], 8'ha6 ^ 8'(i), 1'b0);
    tx_one(8'hc0, 8'h5b, 1'b1);
  endtask
  task automatic t_b2b;
    logic [7:0] v;
    cfg(8'hc4, 1'b0);
    nb = 4'h9;
    wr(ADR_TXB, 8'h31);
    for (int k = 0; k < 50; k++) begin
      rd(ADR_TXST, v);
      if (v[1] === 1'b0)
        break;
    end
    if (v[1] !== 1'b0) begin
      n_errors++;
      $display("mismatch at %0t: buffer full wait timeout", $time);
      end_sim();
    end
    wr(ADR_TXB, 8'hc2);
    wait_tc(n_tc + 2);
    repeat (BT) @(negedge I_CLK);
    chkn(u_aslu_remote_node.rx_q.size(), 2);
    chk(u_aslu_remote_node.rx_q.pop_front(), tx_bits(8'hc4, 8'h31));
    chk(u_aslu_remote_node.rx_q.pop_front(), tx_bits(8'hc4, 8'hc2));
    rdc(ADR_TXST, 8'h00);
  endtask
  task automatic t_rx;
    logic [6:0] rv;
    rv = {<<{7'h4b}};
    cfg(8'ha4, 1'b0);
    rx_chk(12'h1a5, 9, 1, 8'ha5, 8'h00, 1, 0);
    cfg(8'ha0, 1'b0);
    rx_chk(12'h0eb, 8, 1, 8'h6b, 8'h00, 1, 0);
    cfg(8'ha0, 1'b1);
    rx_chk({5'h01, rv}, 8, 1, 8'h96, 8'h00, 1, 0);
    cfg(8'hb4, 1'b0);
    rx_chk(12'h203, 10, 1, 8'h03, 8'h04, 0, 1);
    cfg(8'hac, 1'b0);
    rx_chk(12'h303, 10, 1, 8'h03, 8'h00, 1, 0);
    cfg(8'ha5, 1'b0);
    rx_chk(12'h03c, 9, 1, 8'h3c, 8'h02, 1, 0);
    cfg(8'ha4, 1'b0);
    rx_chk(12'h111, 9, 0, 8'h00, 8'h00, 1, 0);
    rx_chk(12'h122, 9, 1, 8'h11, 8'h01, 0, 1);
  endtask
  task automatic t_off;
    cfg(8'hc4, 1'b0);
    wr(ADR_TXB, 8'h00);
    repeat (3 * BT) @(negedge I_CLK);
    wr(ADR_MODE, 8'h84);
    repeat (3) @(negedge I_CLK);
    chk(12'(O_SERIAL_OUT_PIN), 12'h001);
    rdc(ADR_TXST, 8'h00);
    wr(ADR_MODE, 8'h00);
    rdc(ADR_RXB, 8'hff);
    chk(12'(O_SERIAL_OUT_PIN), 12'h001);
  endtask
  initial begin
    repeat (4) @(posedge I_CLK);
    @(negedge I_CLK);
    I_RST_B = 1'b1;
    t_reset();
    t_tx();
    t_b2b();
    t_rx();
    t_off();
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge I_CLK);
    n_errors++;
    $display("mismatch at %0t: run limit reached", $time);
    end_sim();
  end
endmodule
